// >>> sil_indicators.sv
// Status indicator outputs with GPIO and serial port alternate functions.
`timescale 1ns/1ns
`include "sil_params.svh"
// Operation
// - Three modem driven lines: message pending, coverage, supply low.
// - Each line may instead be GPIO or a serial peripheral port signal.
// - In serial port mode, status line four serves as chip select.
// - Message pending low while a complete outbound message is held.
// - Coverage line low while in radio range, high otherwise.
// - Supply low line low below 3.5V, high above 3.6V, hysteresis between.
// - Supply low line follows the internal low battery event one cycle later.
// - A supply change may take up to 20 seconds to confirm.
module sil_indicators #(
	parameter int unsigned CONFIRM_CYC = `SIL_CONFIRM_CYC
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire sil_pkg::sil_status_s status,
	input wire sil_pkg::sil_fn_e [2:0] line_fn,
	input wire logic [2:0] gpio_out,
	input wire logic [2:0] gpio_oe,
	input wire sil_pkg::sil_spi_s spi_drive,
	input wire logic [2:0] line_in,
	output sil_pkg::sil_pins_s pins,
	output logic [2:0] gpio_in,
	output logic spi_miso,
	output logic status_line_four_o,
	output logic status_line_four_oe,
	output logic supply_low_event
);
	import sil_pkg::*;

	if (CONFIRM_CYC < 1) begin : g_bad_confirm
		$error("CONFIRM_CYC must be at least one cycle");
	end

	localparam int CW = $clog2(CONFIRM_CYC + 1);

	// Pin inputs pass three synchronizer flops and a filter flop; the first is read only by the second.
	logic [2:0] s1_r, s2_r, s3_r, in_r;
	logic [2:0] in_nxt;
	always_comb begin
		in_nxt = in_r;
		for (int i = 0; i < `SIL_LINES; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				in_nxt[i] = s3_r[i];
			end
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s1_r <= `SIL_SYNC_RST;
			s2_r <= `SIL_SYNC_RST;
			s3_r <= `SIL_SYNC_RST;
			in_r <= `SIL_SYNC_RST;
		end else begin
			s1_r <= line_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			in_r <= in_nxt;
		end
	end
	assign gpio_in = in_r;
	assign spi_miso = in_r[`SIL_IDX_LOW];

	// Supply state with hysteresis and a confirmation delay, so a fast
	// swing is not reported until it has persisted for the whole window.
	logic low_r, low_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic want;
	always_comb begin
		want = low_r;
		if (status.below_low) begin
			want = 1'b1;
		end else if (status.above_high) begin
			want = 1'b0;
		end
		low_nxt = low_r;
		cnt_nxt = '0;
		if (want != low_r) begin
			if (cnt_r >= CW'(CONFIRM_CYC - 1)) begin
				low_nxt = want;
			end else begin
				cnt_nxt = cnt_r + 1'b1;
			end
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			low_r <= 1'b0;
			cnt_r <= '0;
		end else begin
			low_r <= low_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	// The event and the line share one source so they cannot drift apart.
	assign supply_low_event = low_r;

	// Output lines are registered; status indication is active low.
	sil_pins_s pins_r, pins_nxt;
	logic [2:0] ind;
	logic [2:0] spi_o;
	logic [2:0] spi_oe;
	logic cs_o_r, cs_o_nxt, cs_oe_r, cs_oe_nxt;
	always_comb begin
		ind[`SIL_IDX_MSG] = ~status.msg_complete;
		ind[`SIL_IDX_COV] = ~status.in_range;
		ind[`SIL_IDX_LOW] = ~low_r;
		spi_o = {1'b0, spi_drive.mosi, spi_drive.clk};
		spi_oe = `SIL_SPI_OE;
		for (int i = 0; i < `SIL_LINES; i++) begin
			unique case (line_fn[i])
				SIL_FN_STATUS: begin
					pins_nxt.o[i] = ind[i];
					pins_nxt.oe[i] = 1'b1;
				end
				SIL_FN_GPIO: begin
					pins_nxt.o[i] = gpio_out[i];
					pins_nxt.oe[i] = gpio_oe[i];
				end
				SIL_FN_SPI: begin
					pins_nxt.o[i] = spi_o[i];
					pins_nxt.oe[i] = spi_oe[i];
				end
				default: begin
					pins_nxt.o[i] = 1'b1;
					pins_nxt.oe[i] = 1'b0;
				end
			endcase
		end
		cs_o_nxt = 1'b1;
		cs_oe_nxt = 1'b0;
		if (line_fn[`SIL_IDX_MSG] == SIL_FN_SPI) begin
			cs_o_nxt = spi_drive.cs_n;
			cs_oe_nxt = 1'b1;
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pins_r <= '{o: `SIL_PINS_RST, oe: `SIL_PINS_RST};
			cs_o_r <= 1'b1;
			cs_oe_r <= 1'b0;
		end else begin
			pins_r <= pins_nxt;
			cs_o_r <= cs_o_nxt;
			cs_oe_r <= cs_oe_nxt;
		end
	end
	assign pins = pins_r;
	assign status_line_four_o = cs_o_r;
	assign status_line_four_oe = cs_oe_r;

	AST_MSG: assert property (
		@(posedge core_clk) disable iff (!resetn)
		line_fn[0] == SIL_FN_STATUS |=> pins.o[0] == !$past(status.msg_complete))
		else $error("message pending line wrong");
	AST_COV: assert property (
		@(posedge core_clk) disable iff (!resetn)
		line_fn[1] == SIL_FN_STATUS |=> pins.o[1] == !$past(status.in_range))
		else $error("coverage line wrong");
	AST_LOW: assert property (
		@(posedge core_clk) disable iff (!resetn)
		line_fn[2] == SIL_FN_STATUS |=> pins.o[2] == !$past(supply_low_event))
		else $error("supply line disagrees with event");
	AST_HYST: assert property (
		@(posedge core_clk) disable iff (!resetn)
		$rose(low_r) |-> $past(status.below_low))
		else $error("supply low set without low voltage");
	AST_FALL: assert property (
		@(posedge core_clk) disable iff (!resetn)
		$fell(low_r) |-> $past(status.above_high))
		else $error("supply low cleared without high voltage");
	AST_HOLD: assert property (
		@(posedge core_clk) disable iff (!resetn)
		!status.below_low && !status.above_high |=> $stable(low_r))
		else $error("supply state moved between thresholds");
	AST_CONF: assert property (
		@(posedge core_clk) disable iff (!resetn)
		$changed(low_r) |-> $past(cnt_r) == CW'(CONFIRM_CYC - 1))
		else $error("supply state changed before confirmation");
	AST_OE: assert property (
		@(posedge core_clk) disable iff (!resetn)
		line_fn[1] == SIL_FN_STATUS |=> pins.oe[1])
		else $error("status line not driven");
	AST_GPIO: assert property (
		@(posedge core_clk) disable iff (!resetn)
		line_fn[0] == SIL_FN_GPIO |=> pins.o[0] == $past(gpio_out[0]))
		else $error("gpio line not followed");
	AST_SPI_OUT: assert property (
		@(posedge core_clk) disable iff (!resetn)
		line_fn[1] == SIL_FN_SPI |=> pins.oe[1] &&
		pins.o[1] == $past(spi_drive.mosi))
		else $error("serial data line not driven");
	AST_MISO_IN: assert property (
		@(posedge core_clk) disable iff (!resetn)
		line_fn[2] == SIL_FN_SPI |=> !pins.oe[2])
		else $error("serial input line driven");
	AST_CS: assert property (
		@(posedge core_clk) disable iff (!resetn)
		line_fn[0] == SIL_FN_SPI |=> status_line_four_oe &&
		status_line_four_o == $past(spi_drive.cs_n))
		else $error("chip select not driven");
	AST_CS_OFF: assert property (
		@(posedge core_clk) disable iff (!resetn)
		line_fn[0] != SIL_FN_SPI |=> !status_line_four_oe)
		else $error("chip select driven outside serial mode");

	// Per-line checks; release and gpio enable are judged against the line's function, the input filter check holds in every function.
	for (genvar g = 0; g < `SIL_LINES; g++) begin : g_line_chk
		AST_LINE_OFF: assert property (
			@(posedge core_clk) disable iff (!resetn)
			!(line_fn[g] inside {SIL_FN_STATUS, SIL_FN_GPIO, SIL_FN_SPI})
			|=> !pins.oe[g] && pins.o[g])
			else $error("illegal function did not release the line");
		AST_GPIO_OE: assert property (
			@(posedge core_clk) disable iff (!resetn)
			line_fn[g] == SIL_FN_GPIO |=> pins.oe[g] == $past(gpio_oe[g]))
			else $error("gpio enable not followed");
		AST_IN_FILT: assert property (
			@(posedge core_clk) disable iff (!resetn)
			$changed(gpio_in[g]) |-> $past(s2_r[g]) == $past(s3_r[g]))
			else $error("pin input changed before the filter agreed");
	end
endmodule : sil_indicators

// >>> sil_params.svh
// Timing and encoding constants for the status indicator line block.
`ifndef SIL_PARAMS_SVH
`define SIL_PARAMS_SVH
`define SIL_CLK_HZ 20000000
`define SIL_CONFIRM_S 20
`define SIL_CONFIRM_CYC (`SIL_CONFIRM_S * `SIL_CLK_HZ)
`define SIL_LINES 3
`define SIL_IDX_MSG 0
`define SIL_IDX_COV 1
`define SIL_IDX_LOW 2
`define SIL_SYNC_RST 3'h0
`define SIL_PINS_RST 3'h7
`define SIL_SPI_OE 3'h3
`endif

// >>> sil_pkg.sv
// Types shared by the status indicator line block.
package sil_pkg;
	typedef enum logic [1:0] {
		SIL_FN_STATUS = 2'h0,
		SIL_FN_GPIO = 2'h1,
		SIL_FN_SPI = 2'h3
	} sil_fn_e;
	typedef struct packed {
		logic msg_complete;
		logic in_range;
		logic below_low;
		logic above_high;
	} sil_status_s;
	typedef struct packed {
		logic [2:0] o;
		logic [2:0] oe;
	} sil_pins_s;
	typedef struct packed {
		logic clk;
		logic mosi;
		logic cs_n;
	} sil_spi_s;
endpackage : sil_pkg

// >>> sil_far_host.sv
// Far-side host logic model for the indicator lines.
`timescale 1ns/1ns
module sil_far_host (
	input wire sil_pkg::sil_pins_s pins,
	input wire logic [2:0] ext_val,
	output logic [2:0] line_in
);
	import sil_pkg::*;
	// A driven line reads its own level; a released one the host level.
	assign line_in = (pins.o & pins.oe) | (ext_val & ~pins.oe);
endmodule : sil_far_host

// >>> tb_sil_indicators.sv
// Testbench for the status indicator lines.
`timescale 1ns/1ns
module tb_sil_indicators;
	import sil_pkg::*;
	localparam int CONF = 8;
	logic core_clk = 0;
	logic resetn = 0;
	sil_status_s status = '0;
	sil_fn_e [2:0] line_fn;
	logic [2:0] gpio_out = 3'h0;
	logic [2:0] gpio_oe = 3'h0;
	sil_spi_s spi_drive = '0;
	logic [2:0] ext_val = 3'h0;
	logic [2:0] line_in;
	sil_pins_s pins;
	logic [2:0] gpio_in;
	logic miso, sl4_o, sl4_oe, ev;
	int errors = 0;
	int n_compared = 0;
	always #25 core_clk = ~core_clk;
	sil_indicators #(.CONFIRM_CYC(CONF)) dut (.core_clk(core_clk),
		.resetn(resetn), .status(status), .line_fn(line_fn),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .spi_drive(spi_drive),
		.line_in(line_in), .pins(pins), .gpio_in(gpio_in),
		.spi_miso(miso), .status_line_four_o(sl4_o),
		.status_line_four_oe(sl4_oe), .supply_low_event(ev));
	sil_far_host far (.pins(pins), .ext_val(ext_val), .line_in(line_in));
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
		#5;
	endtask : cyc
	task chk(input string nm, input logic [2:0] e, input logic [2:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task fn(input sil_fn_e f);
		for (int i = 0; i < 3; i++) begin
			line_fn[i] = f;
		end
	endtask : fn
	task conclude;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : conclude
	task t_status;
		status.msg_complete = 1'b1;
		cyc(1);
		chk("pins", 3'h6, pins.o);
		chk("oe", 3'h7, pins.oe);
		status = 4'h4;
		cyc(1);
		chk("pins", 3'h5, pins.o);
		status = '0;
		cyc(1);
		chk("pins", 3'h7, pins.o);
		$display("status done");
	endtask : t_status
	task t_supply;
		// A short dip must be ignored, so it is shorter than the confirm time.
		status.below_low = 1'b1;
		cyc(3);
		status.below_low = 1'b0;
		cyc(CONF + 2);
		chk("event", 3'h0, {2'h0, ev});
		status.below_low = 1'b1;
		cyc(CONF - 3);
		chk("event", 3'h0, {2'h0, ev});
		cyc(5);
		chk("event", 3'h1, {2'h0, ev});
		chk("pins", 3'h3, pins.o);
		status.below_low = 1'b0;
		cyc(CONF + 2);
		chk("pins", 3'h3, pins.o);
		status.above_high = 1'b1;
		cyc(CONF + 2);
		chk("pins", 3'h7, pins.o);
		status = '0;
		$display("supply done");
	endtask : t_supply
	task t_gpio;
		status.msg_complete = 1'b1;
		fn(SIL_FN_GPIO);
		gpio_out = 3'h5;
		gpio_oe = 3'h3;
		ext_val = 3'h2;
		cyc(1);
		chk("pins", 3'h5, pins.o);
		chk("oe", 3'h3, pins.oe);
		cyc(6);
		chk("gpio_in", 3'h1, gpio_in);
		fn(sil_fn_e'(2'h2));
		cyc(1);
		chk("oe", 3'h0, pins.oe);
		status = '0;
		$display("gpio done");
	endtask : t_gpio
	task t_spi;
		fn(SIL_FN_SPI);
		ext_val = 3'h4;
		spi_drive = 3'h4;
		cyc(1);
		chk("spi", 3'h1, {1'b0, pins.o[1:0]});
		chk("oe", 3'h3, pins.oe);
		chk("cs", 3'h2, {1'b0, sl4_oe, sl4_o});
		cyc(6);
		chk("miso", 3'h1, {2'h0, miso});
		spi_drive = 3'h3;
		cyc(1);
		chk("spi", 3'h2, {1'b0, pins.o[1:0]});
		chk("cs", 3'h3, {1'b0, sl4_oe, sl4_o});
		$display("spi done");
	endtask : t_spi
	task t_reset;
		// Reset mid-run with the supply state set and the chip select low.
		status.below_low = 1'b1;
		spi_drive = 3'h0;
		cyc(CONF + 1);
		chk("event", 3'h1, {2'h0, ev});
		chk("cs", 3'h2, {1'b0, sl4_oe, sl4_o});
		chk("gpio_in", 3'h4, gpio_in);
		resetn = 1'b0;
		cyc(2);
		chk("pins", 3'h7, pins.o);
		chk("oe", 3'h7, pins.oe);
		chk("cs", 3'h1, {1'b0, sl4_oe, sl4_o});
		chk("gpio_in", 3'h0, gpio_in);
		chk("event", 3'h0, {2'h0, ev});
		fn(SIL_FN_STATUS);
		status = 4'h8;
		resetn = 1'b1;
		cyc(1);
		chk("pins", 3'h6, pins.o);
		status = '0;
		$display("reset done");
	endtask : t_reset
	initial begin
		fn(SIL_FN_STATUS);
		cyc(8);
		resetn = 1'b1;
		chk("oe", 3'h7, pins.oe);
		t_status();
		t_supply();
		t_gpio();
		t_spi();
		t_reset();
		conclude();
	end
endmodule : tb_sil_indicators
